// ===== hdl/uart_timer_baud.sv
// Full-duplex serial port with timer-driven baud generation and Avalon-MM registers
`timescale 1ns/1ps
`include "uart_timer_baud_params.svh"
// Behaviour
// - Full-duplex async port, 8-bit and 9-bit variable-rate frame modes.
// - Received byte buffered; next reception may start before software reads it.
// - Writing the data buffer loads the transmit register and starts sending.
// - Reading the data buffer returns the receive buffer; transmit register unreadable.
// - When enabled, interrupt on transmit done or receive done flag.
// - Hardware never clears the done flags; software clears them.
// - Baud clock comes from 8-bit auto-reload timer overflows.
// - Transmit uses timer low counter; receive uses hidden counter copy.
// - Both overflow streams are divided by two for bit rate.
// - Receive copy counts while timer runs, reloading from reload_byte.
// - Start condition on the input forces reload of the receive copy.
// - Overflow rate is timer clock over 256 minus reload; bit rate half.
// - Timer clock: system clock /4, /12, /48, external oscillator /8, pin.
// - System clock stays independent of external oscillator feeding the timer.
// - 8-bit frame: start, eight data LSB first, stop; stop to rx_ninth_bit.
// - 9-bit frame adds tx_ninth_bit; received ninth to rx_ninth_bit, stop ignored.
// - Load and flag only if rx_done_flag clear and multiproc check passes.
// - Reception needs receiver_enable_bit; frame_width_select 0 is 8-bit, 1 is 9-bit.
module uart_timer_baud #(
   parameter int PRESCALE_W = 6
) (
   // Clock and reset
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_sys_rst,
   // Avalon-MM slave
   input  wire logic [4:0]                  i_avs_address,
   input  wire logic                        i_avs_read,
   input  wire logic                        i_avs_write,
   input  wire logic [31:0]                 i_avs_writedata,
   output logic      [31:0]                 o_avs_readdata,
   output logic                             o_avs_waitrequest,
   // Timer clock sources
   input  wire logic                        i_ext_osc,
   input  wire logic                        i_timer_ext_input,
   // Serial pins
   input  wire logic                        i_serial_in_pin,
   output logic                             o_serial_out_pin,
   // Port interrupt
   output logic                             o_port_irq,
   // Transmitter state
   output uart_timer_baud_pkg::tx_state_t   o_tx_state
);
   import uart_timer_baud_pkg::*;

   // Refused at elaboration: a narrower prescaler could never reach the /48 limit
   if (PRESCALE_W < 6) begin : g_bad_prescale
      $error("PRESCALE_W must hold a count of 48");
   end

   // ---------------- Register bus ----------------
   logic             ack_reg, ack_next;
   logic [31:0]      rdata_reg, rdata_next;
   logic [7:0]       ctrl_reg, ctrl_next;
   logic [7:0]       tctrl_reg, tctrl_next;
   logic [7:0]       reload_reg, reload_next;
   logic [7:0]       rxbuf_reg, rxbuf_next;
   logic             wr_take;
   logic             wr_data;
   logic             wr_ctrl;
   logic             wr_timer_low;

   // Receive and transmit hooks into the registers
   logic             rx_load;
   logic [7:0]       rx_load_data;
   logic             rx_load_ninth;
   logic             tx_done_set;
   logic [7:0]       tl_reg;

   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
   assign wr_take           = i_avs_write & ack_reg;
   assign wr_ctrl           = wr_take & (i_avs_address == `OFS_SERIAL_CONTROL);
   assign wr_data           = wr_take & (i_avs_address == `OFS_SERIAL_DATA);
   assign wr_timer_low      = wr_take & (i_avs_address == `OFS_TIMER_LOW);
   assign o_avs_readdata    = rdata_reg;
   assign o_port_irq        = tctrl_reg[`BIT_PORT_IRQ_EN] &
                              (ctrl_reg[`BIT_TX_DONE] | ctrl_reg[`BIT_RX_DONE]);

   always_comb begin
      ack_next    = (i_avs_read | i_avs_write) & ~ack_reg;
      rdata_next  = rdata_reg;
      ctrl_next   = ctrl_reg;
      tctrl_next  = tctrl_reg;
      reload_next = reload_reg;
      rxbuf_next  = rxbuf_reg;
      // Answer one cycle after the request; data prepared in the first cycle
      if (i_avs_read && !ack_reg) begin
         case (i_avs_address)
            `OFS_SERIAL_CONTROL: rdata_next = {24'h000000, ctrl_reg};
            `OFS_SERIAL_DATA:    rdata_next = {24'h000000, rxbuf_reg};
            `OFS_TIMER_CONTROL:  rdata_next = {24'h000000, tctrl_reg};
            `OFS_RELOAD_BYTE:    rdata_next = {24'h000000, reload_reg};
            `OFS_TIMER_LOW:      rdata_next = {24'h000000, tl_reg};
            default:             rdata_next = 32'h00000000;
         endcase
      end
      if (wr_ctrl) begin
         ctrl_next = {i_avs_writedata[7], 1'b1, i_avs_writedata[5:0]};
      end
      if (wr_take && i_avs_address == `OFS_TIMER_CONTROL)
         tctrl_next = {3'b000, i_avs_writedata[4:0]};
      if (wr_take && i_avs_address == `OFS_RELOAD_BYTE)
         reload_next = i_avs_writedata[7:0];
      // Hardware only ever sets the flags; a set in the same cycle beats a clear
      if (tx_done_set)
         ctrl_next[`BIT_TX_DONE] = 1'b1;
      if (rx_load) begin
         ctrl_next[`BIT_RX_DONE]  = 1'b1;
         ctrl_next[`BIT_RX_NINTH] = rx_load_ninth;
         rxbuf_next               = rx_load_data;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ack_reg    <= 1'b0;
         rdata_reg  <= 32'h00000000;
         ctrl_reg   <= `RST_SERIAL_CONTROL;
         tctrl_reg  <= `RST_TIMER_CONTROL;
         reload_reg <= `RST_RELOAD_BYTE;
         rxbuf_reg  <= `RST_DATA_BUFFER;
      end else begin
         ack_reg    <= ack_next;
         rdata_reg  <= rdata_next;
         ctrl_reg   <= ctrl_next;
         tctrl_reg  <= tctrl_next;
         reload_reg <= reload_next;
         rxbuf_reg  <= rxbuf_next;
      end
   end

   // ---------------- Timer clock and counters ----------------
   // The port logic stays on i_ref_clk; the external oscillator only supplies ticks
   timer_clk_sel_t          clk_sel;
   logic [PRESCALE_W-1:0]   pre_reg, pre_next;
   logic                    osc_prev_reg, pin_prev_reg;
   logic                    timer_tick;
   logic                    pre_inc;
   logic [PRESCALE_W-1:0]   pre_limit;
   logic                    timer_run;
   logic [7:0]              tl_next;
   logic [7:0]              rxt_reg, rxt_next;
   logic                    tx_ovf, rx_ovf;
   logic                    tx_half_reg, tx_half_next;
   logic                    rx_half_reg, rx_half_next;
   logic                    rx_force_reload;

   assign clk_sel   = timer_clk_sel_t'(tctrl_reg[`POS_CLK_SELECT +: 3]);
   assign timer_run = tctrl_reg[`BIT_TIMER_RUN];

   always_comb begin
      pre_inc   = 1'b1;
      pre_limit = PRESCALE_W'(`DIV_SYS_12);
      case (clk_sel)
         CLK_SYS_DIV12: pre_limit = PRESCALE_W'(`DIV_SYS_12);
         CLK_SYS_DIV4:  pre_limit = PRESCALE_W'(`DIV_SYS_4);
         CLK_SYS_DIV48: pre_limit = PRESCALE_W'(`DIV_SYS_48);
         CLK_EXT_OSC8: begin
            pre_limit = PRESCALE_W'(`DIV_EXT_OSC);
            pre_inc   = i_ext_osc & ~osc_prev_reg;
         end
         default: begin
            pre_limit = PRESCALE_W'(1);
            pre_inc   = i_timer_ext_input & ~pin_prev_reg;
         end
      endcase
      pre_next   = pre_reg;
      timer_tick = 1'b0;
      if (pre_inc) begin
         if (pre_reg >= pre_limit - PRESCALE_W'(1)) begin
            pre_next   = '0;
            timer_tick = timer_run;
         end else begin
            pre_next = pre_reg + PRESCALE_W'(1);
         end
      end
      // Auto-reload counters: overflow every 256 - reload ticks
      tl_next = tl_reg;
      tx_ovf  = 1'b0;
      if (wr_timer_low) begin
         tl_next = i_avs_writedata[7:0];
      end else if (timer_tick) begin
         if (tl_reg == 8'hff) begin
            tl_next = reload_reg;
            tx_ovf  = 1'b1;
         end else begin
            tl_next = tl_reg + 8'h01;
         end
      end
      rxt_next = rxt_reg;
      rx_ovf   = 1'b0;
      if (rx_force_reload) begin
         rxt_next = reload_reg;
      end else if (timer_tick) begin
         if (rxt_reg == 8'hff) begin
            rxt_next = reload_reg;
            rx_ovf   = 1'b1;
         end else begin
            rxt_next = rxt_reg + 8'h01;
         end
      end
      // Halving: a bit time spans two overflows
      tx_half_next = tx_ovf ? ~tx_half_reg : tx_half_reg;
      rx_half_next = rx_force_reload ? 1'b0 : (rx_ovf ? ~rx_half_reg : rx_half_reg);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         pre_reg      <= '0;
         osc_prev_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
         tl_reg       <= `RST_TIMER_LOW;
         rxt_reg      <= `RST_TIMER_LOW;
         tx_half_reg  <= 1'b0;
         rx_half_reg  <= 1'b0;
      end else begin
         pre_reg      <= pre_next;
         osc_prev_reg <= i_ext_osc;
         pin_prev_reg <= i_timer_ext_input;
         tl_reg       <= tl_next;
         rxt_reg      <= rxt_next;
         tx_half_reg  <= tx_half_next;
         rx_half_reg  <= rx_half_next;
      end
   end

   // ---------------- Transmitter ----------------
   tx_state_t        tx_state_reg, tx_state_next;
   logic [10:0]      tx_shift_reg, tx_shift_next;
   logic [3:0]       tx_cnt_reg, tx_cnt_next;
   logic [3:0]       tx_len_reg, tx_len_next;
   logic             tx_out_reg, tx_out_next;
   logic             tx_bit_tick;

   assign tx_bit_tick      = tx_ovf & tx_half_reg;
   assign o_serial_out_pin = tx_out_reg;
   assign o_tx_state       = tx_state_reg;

   always_comb begin
      tx_state_next = tx_state_reg;
      tx_shift_next = tx_shift_reg;
      tx_cnt_next   = tx_cnt_reg;
      tx_len_next   = tx_len_reg;
      tx_out_next   = tx_out_reg;
      tx_done_set   = 1'b0;
      if (wr_data) begin
         // A write during a frame restarts with the new byte
         tx_state_next = TX_ALIGN;
         tx_cnt_next   = 4'd0;
         tx_out_next   = 1'b1;
         if (ctrl_reg[`BIT_FRAME_WIDTH]) begin
            tx_shift_next = {1'b1, ctrl_reg[`BIT_TX_NINTH], i_avs_writedata[7:0], 1'b0};
            tx_len_next   = `FRAME_BITS_9;
         end else begin
            tx_shift_next = {2'b11, i_avs_writedata[7:0], 1'b0};
            tx_len_next   = `FRAME_BITS_8;
         end
      end else begin
         case (tx_state_reg)
            TX_IDLE: tx_out_next = 1'b1;
            TX_ALIGN: begin
               // Wait for a bit boundary so the start bit has full length
               if (tx_bit_tick) begin
                  tx_state_next = TX_SHIFT;
                  tx_out_next   = tx_shift_reg[0];
                  tx_shift_next = {1'b1, tx_shift_reg[10:1]};
                  tx_cnt_next   = 4'd1;
               end
            end
            TX_SHIFT: begin
               if (tx_bit_tick) begin
                  if (tx_cnt_reg == tx_len_reg) begin
                     tx_state_next = TX_IDLE;
                     tx_out_next   = 1'b1;
                  end else begin
                     tx_out_next   = tx_shift_reg[0];
                     tx_shift_next = {1'b1, tx_shift_reg[10:1]};
                     tx_cnt_next   = tx_cnt_reg + 4'd1;
                     // Flag at the start of the stop bit
                     tx_done_set   = (tx_cnt_reg == tx_len_reg - 4'd1);
                  end
               end
            end
            default: tx_state_next = TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 11'h7ff;
         tx_cnt_reg   <= 4'd0;
         tx_len_reg   <= `FRAME_BITS_8;
         tx_out_reg   <= 1'b1;
      end else begin
         tx_state_reg <= tx_state_next;
         tx_shift_reg <= tx_shift_next;
         tx_cnt_reg   <= tx_cnt_next;
         tx_len_reg   <= tx_len_next;
         tx_out_reg   <= tx_out_next;
      end
   end

   // ---------------- Receiver ----------------
   rx_state_t        rx_state_reg, rx_state_next;
   logic [8:0]       rx_shift_reg, rx_shift_next;
   logic [3:0]       rx_cnt_reg, rx_cnt_next;
   logic             rx_prev_reg;
   logic             rx_sample;
   logic             rx_nine;
   logic             rx_ninth_val;

   // Sampling at the first overflow after a boundary lands mid-bit
   assign rx_sample = rx_ovf & ~rx_half_reg;
   assign rx_nine   = ctrl_reg[`BIT_FRAME_WIDTH];

   always_comb begin
      rx_state_next   = rx_state_reg;
      rx_shift_next   = rx_shift_reg;
      rx_cnt_next     = rx_cnt_reg;
      rx_force_reload = 1'b0;
      rx_load         = 1'b0;
      rx_ninth_val    = rx_nine ? rx_shift_reg[8] : i_serial_in_pin;
      rx_load_ninth   = rx_ninth_val;
      rx_load_data    = rx_nine ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
      if (!ctrl_reg[`BIT_RX_ENABLE]) begin
         rx_state_next = RX_IDLE;
      end else begin
         case (rx_state_reg)
            RX_IDLE: begin
               if (rx_prev_reg && !i_serial_in_pin) begin
                  rx_force_reload = 1'b1;
                  rx_state_next   = RX_START;
               end
            end
            RX_START: begin
               if (rx_sample) begin
                  // A start bit gone high at mid-bit was a glitch
                  rx_state_next = i_serial_in_pin ? RX_IDLE : RX_DATA;
                  rx_cnt_next   = 4'd0;
               end
            end
            RX_DATA: begin
               if (rx_sample) begin
                  rx_shift_next = {i_serial_in_pin, rx_shift_reg[8:1]};
                  rx_cnt_next   = rx_cnt_reg + 4'd1;
                  if (rx_cnt_reg == (rx_nine ? 4'd8 : 4'd7))
                     rx_state_next = RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_sample) begin
                  rx_state_next = RX_IDLE;
                  // Overrun drops the new byte and keeps the buffered one
                  rx_load = ~ctrl_reg[`BIT_RX_DONE] &
                            (~ctrl_reg[`BIT_MULTIPROC] | rx_ninth_val);
               end
            end
            default: rx_state_next = RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         rx_state_reg <= RX_IDLE;
         rx_shift_reg <= 9'h000;
         rx_cnt_reg   <= 4'd0;
         rx_prev_reg  <= 1'b1;
      end else begin
         rx_state_reg <= rx_state_next;
         rx_shift_reg <= rx_shift_next;
         rx_cnt_reg   <= rx_cnt_next;
         rx_prev_reg  <= i_serial_in_pin;
      end
   end
endmodule : uart_timer_baud

// ===== hdl/uart_timer_baud_params.svh
// Offsets, field positions, reset values and timing counts of the serial port
`ifndef UART_TIMER_BAUD_PARAMS_SVH
`define UART_TIMER_BAUD_PARAMS_SVH
// Byte addresses on the register bus
`define OFS_SERIAL_CONTROL 5'h00
`define OFS_SERIAL_DATA    5'h04
`define OFS_TIMER_CONTROL  5'h08
`define OFS_RELOAD_BYTE    5'h0c
`define OFS_TIMER_LOW      5'h10
// serial_control_reg fields
`define BIT_FRAME_WIDTH    7
`define BIT_FIXED_ONE      6
`define BIT_MULTIPROC      5
`define BIT_RX_ENABLE      4
`define BIT_TX_NINTH       3
`define BIT_RX_NINTH       2
`define BIT_TX_DONE        1
`define BIT_RX_DONE        0
// timer_control_reg fields
`define POS_CLK_SELECT     0
`define BIT_TIMER_RUN      3
`define BIT_PORT_IRQ_EN    4
// Reset values
`define RST_SERIAL_CONTROL 8'h40
`define RST_TIMER_CONTROL  8'h00
`define RST_RELOAD_BYTE    8'h00
`define RST_TIMER_LOW      8'h00
`define RST_DATA_BUFFER    8'h00
// Timer input clock dividers
`define DIV_SYS_4          6'd4
`define DIV_SYS_12         6'd12
`define DIV_SYS_48         6'd48
`define DIV_EXT_OSC        6'd8
// Frame lengths in bit times
`define FRAME_BITS_8       4'd10
`define FRAME_BITS_9       4'd11
`endif

// ===== hdl/uart_timer_baud_pkg.sv
// Types shared by the serial port with timer baud generation
package uart_timer_baud_pkg;
   typedef enum logic [2:0] {
      CLK_SYS_DIV12 = 3'b000,
      CLK_SYS_DIV4  = 3'b001,
      CLK_SYS_DIV48 = 3'b010,
      CLK_EXT_OSC8  = 3'b011,
      CLK_EXT_PIN   = 3'b100
   } timer_clk_sel_t;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_ALIGN = 2'b01,
      TX_SHIFT = 2'b10
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_t;
endpackage : uart_timer_baud_pkg

// ===== tb/uart_timer_baud_chk.sv
// Port-level assertions for the timer-paced serial port
`timescale 1ns/1ps
`include "uart_timer_baud_params.svh"
module uart_timer_baud_chk (
   // Clock and reset
   input wire logic                      i_ref_clk,
   input wire logic                      i_sys_rst,
   // Register bus
   input wire logic [4:0]                i_avs_address,
   input wire logic                      i_avs_read,
   input wire logic                      i_avs_write,
   input wire logic [31:0]               o_avs_readdata,
   input wire logic                      o_avs_waitrequest,
   // Serial side
   input wire logic                      o_serial_out_pin,
   input wire logic                      o_port_irq,
   input wire uart_timer_baud_pkg::tx_state_t o_tx_state
);
   import uart_timer_baud_pkg::*;
   logic req;
   logic wr_done;
   logic wr_done_reg;
   assign req = i_avs_read | i_avs_write;
   assign wr_done = i_avs_write & ~o_avs_waitrequest;
   always_ff @(posedge i_ref_clk) begin
      wr_done_reg <= wr_done;
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   sequence tx_begin;
      o_tx_state == TX_ALIGN ##1 o_tx_state == TX_SHIFT;
   endsequence
   sequence data_write;
      wr_done && i_avs_address == `OFS_SERIAL_DATA;
   endsequence
   AST_WAIT_ONE: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("waitrequest held beyond one wait cycle");
   AST_NO_IDLE_WAIT: assert property (!req |-> !o_avs_waitrequest)
      else $error("waitrequest high without a request");
   AST_READ_UPPER: assert property (o_avs_readdata[31:8] == 24'h0)
      else $error("read data upper lanes not zero");
   AST_READ_HOLDS: assert property (!i_avs_read |=> $stable(o_avs_readdata))
      else $error("read data changed without a read");
   AST_RESET_IDLE: assert property ($fell(i_sys_rst) |-> o_serial_out_pin && !o_port_irq && o_tx_state == TX_IDLE)
      else $error("outputs not idle after reset");
   AST_IDLE_HIGH: assert property (o_tx_state == TX_IDLE |-> o_serial_out_pin)
      else $error("serial output low while idle");
   AST_WRITE_ARMS: assert property (data_write |-> ##[1:2] o_tx_state == TX_ALIGN)
      else $error("data write did not arm the transmitter");
   AST_START_LOW: assert property (tx_begin |-> ##[0:1] !o_serial_out_pin)
      else $error("no start bit when shifting began");
   AST_SW_CLEAR: assert property ($fell(o_port_irq) |-> wr_done_reg)
      else $error("interrupt dropped without a register write");
endmodule : uart_timer_baud_chk

bind uart_timer_baud uart_timer_baud_chk i_chk (
   .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .o_serial_out_pin(o_serial_out_pin),
   .o_port_irq(o_port_irq), .o_tx_state(o_tx_state));

// ===== tb/serial_peer.sv
// Remote serial transceiver facing the serial pins
`timescale 1ns/1ps
module serial_peer (
   // Clock
   input  wire logic i_clk,
   // Serial pins
   input  wire logic i_line,
   output logic      o_line
);
   int         bit_cyc = 32;
   logic       nine = 1'b0;
   logic [8:0] got;
   logic       got_stop;
   int         got_count = 0;

   // Line rests high between frames, as a pulled-up idle line would
   initial o_line = 1'b1;

   // In 8-bit frames b9 is the stop level itself
   task automatic send(input logic [7:0] d, input logic b9);
      logic [10:0] f;
      f = {1'b1, b9, d, 1'b0};
      for (int k = 0; k < (nine ? 11 : 10); k++) begin
         o_line <= f[k];
         repeat (bit_cyc) @(posedge i_clk);
      end
   endtask : send

   // Mid-bit sampling of the device's frames, LSB first
   initial begin
      forever begin
         @(negedge i_line);
         got = 9'h000;
         repeat (bit_cyc / 2) @(posedge i_clk);
         for (int k = 0; k < (nine ? 9 : 8); k++) begin
            repeat (bit_cyc) @(posedge i_clk);
            got[k] = i_line;
         end
         repeat (bit_cyc) @(posedge i_clk);
         got_stop = i_line;
         got_count++;
      end
   end
endmodule : serial_peer

// ===== tb/uart_timer_baud_tb.sv
// Register-level bench of the serial port against a remote transceiver
`timescale 1ns/1ps
`include "uart_timer_baud_params.svh"
module uart_timer_baud_tb;
   import uart_timer_baud_pkg::*;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [4:0]  addr = 5'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        wreq;
   logic        ext_osc = 1'b0;
   logic        ext_pin = 1'b0;
   logic [1:0]  pin_div = 2'h0;
   logic        rx_line;
   logic        tx_line;
   logic        irq;
   tx_state_t   tx_state;
   int          fail_count = 0;
   int          compares = 0;
   logic [2:0]  sel_t [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h1};
   logic [7:0]  rl_t [5] = '{8'hfe, 8'hff, 8'hff, 8'hfc, 8'hfc};
   int          bc_t [5] = '{48, 96, 32, 32, 32};

   always #12.5 ref_clk = ~ref_clk;
   // Oscillator edges every 2 cycles, timer pin edges every 4
   always @(posedge ref_clk) begin
      ext_osc <= ~ext_osc;
      pin_div <= pin_div + 2'h1;
      ext_pin <= pin_div[1];
   end

   uart_timer_baud #(.PRESCALE_W(6)) i_dut (
      .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .i_ext_osc(ext_osc), .i_timer_ext_input(ext_pin),
      .i_serial_in_pin(rx_line), .o_serial_out_pin(tx_line), .o_port_irq(irq),
      .o_tx_state(tx_state));
   serial_peer i_peer (.i_clk(ref_clk), .i_line(tx_line), .o_line(rx_line));

   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
      end
   endtask : check

   // Bounded wait step; running out counts as a mismatch
   task automatic tick(inout int n);
      @(posedge ref_clk);
      n++;
      if (n > 4000) begin
         fail_count++;
         $display("unexpected at %0t: wait ran out", $time);
         test_done();
      end
   endtask : tick

   // Request held until waitrequest is sampled low, then released
   task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      addr <= a;
      rd <= ~w;
      wr <= w;
      wdata <= {24'h0, d};
      do tick(n); while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge ref_clk);
   endtask : bus

   task automatic wr8(input logic [4:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask : wr8

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input string s);
      logic [31:0] q;
      bus(a, 1'b0, 8'h00, q);
      check(q, {24'h0, e}, s);
   endtask : rd_chk

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1) tick(n);
   endtask : wait_irq

   initial begin
      int n;
      int cnt;
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rd_chk(`OFS_SERIAL_CONTROL, `RST_SERIAL_CONTROL, "control reset");
      rd_chk(`OFS_SERIAL_DATA, `RST_DATA_BUFFER, "data reset");
      rd_chk(5'h1c, 8'h00, "unmapped read");
      // Timer still stopped, so the loaded low byte must hold
      wr8(`OFS_TIMER_LOW, 8'h5c);
      rd_chk(`OFS_TIMER_LOW, 8'h5c, "timer low stopped");
      wr8(`OFS_SERIAL_CONTROL, 8'h10);
      // Every clock source with its own reload and bit time
      for (int i = 0; i < 5; i++) begin
         wr8(`OFS_TIMER_CONTROL, {5'h03, sel_t[i]});
         wr8(`OFS_RELOAD_BYTE, rl_t[i]);
         rd_chk(`OFS_RELOAD_BYTE, rl_t[i], "reload byte");
         i_peer.bit_cyc = bc_t[i];
         cnt = i_peer.got_count;
         wr8(`OFS_SERIAL_DATA, 8'ha0 + 8'(i));
         n = 0;
         while (i_peer.got_count == cnt) tick(n);
         check({24'h0, i_peer.got[7:0]}, {24'h0, 8'ha0 + 8'(i)}, "tx byte");
         check({31'h0, i_peer.got_stop}, 32'h1, "tx stop");
         check({31'h0, irq}, 32'h1, "tx irq");
         rd_chk(`OFS_SERIAL_CONTROL, 8'h52, "tx done flag");
         n = 0;
         while (tx_state !== TX_IDLE) tick(n);
         wr8(`OFS_SERIAL_CONTROL, 8'h10);
         check({31'h0, irq}, 32'h0, "tx flag cleared");
      end
      // Second frame follows back to back; the first is read before the second starts
      fork
         begin
            i_peer.send(8'h3c, 1'b1);
            i_peer.send(8'hc3, 1'b1);
         end
         begin
            wait_irq();
            rd_chk(`OFS_SERIAL_CONTROL, 8'h55, "rx flags");
            rd_chk(`OFS_SERIAL_DATA, 8'h3c, "rx first");
            wr8(`OFS_SERIAL_CONTROL, 8'h10);
            wait_irq();
            rd_chk(`OFS_SERIAL_DATA, 8'hc3, "rx second");
         end
      join
      i_peer.send(8'h99, 1'b1);
      rd_chk(`OFS_SERIAL_DATA, 8'hc3, "overrun kept");
      wr8(`OFS_SERIAL_CONTROL, 8'h98);
      i_peer.nine = 1'b1;
      cnt = i_peer.got_count;
      wr8(`OFS_SERIAL_DATA, 8'h5a);
      n = 0;
      while (i_peer.got_count == cnt) tick(n);
      check({23'h0, i_peer.got}, 32'h15a, "tx ninth");
      n = 0;
      while (tx_state !== TX_IDLE) tick(n);
      wr8(`OFS_SERIAL_CONTROL, 8'hb0);
      i_peer.send(8'h11, 1'b0);
      check({31'h0, irq}, 32'h0, "mce refused");
      i_peer.send(8'h22, 1'b1);
      wait_irq();
      rd_chk(`OFS_SERIAL_CONTROL, 8'hf5, "rx ninth");
      rd_chk(`OFS_SERIAL_DATA, 8'h22, "rx address");
      wr8(`OFS_SERIAL_CONTROL, 8'h00);
      i_peer.nine = 1'b0;
      i_peer.send(8'h77, 1'b1);
      check({31'h0, irq}, 32'h0, "rx disabled");
      rd_chk(`OFS_SERIAL_DATA, 8'h22, "rx disabled data");
      test_done();
   end
endmodule : uart_timer_baud_tb
